// File: design/ssf_sample_fifo_control.sv
`timescale 1ns/1ps
`default_nettype none
module ssf_sample_fifo_control
  import ssf_pkg::*;
#(
  parameter int WORD_BITS     = ssf_pkg::SSF_WORD_BITS,
  parameter int INGRESS_DEPTH = ssf_pkg::SSF_INGRESS_DEPTH
) (
  // clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    resetn,
  // register access from the host port
  input  wire ssf_pkg::ssf_reg_req_type regReq,
  output var  logic [7:0]              regRdData,
  output var  logic                    regRdValid,
  // predefined command from the host command port
  input  wire logic                    cmdEnterRead,
  // sensor samples
  input  wire ssf_pkg::ssf_sample_type sampleIn,
  output var  logic                    sampleReady,
  // state seen by the rest of the device
  output var  logic                    readPhase
);
  import ssf_pkg::*;

  localparam int PW = $clog2(SSF_MAX_DEPTH);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [7:0]           threshold_q;
  logic [1:0]           depth_q;
  ssf_policy_type       policy_q;
  logic                 overrun_q;
  logic                 highByte_q;
  logic [WORD_BITS-1:0] store [SSF_MAX_DEPTH];
  logic [PW-1:0]        wrPtr_q;
  logic [PW-1:0]        rdPtr_q;
  logic [PW:0]          count_q;
  logic [PW:0]          capacity;
  logic [PW-1:0]        ptrMask;
  logic [9:0]           wordCount;
  logic                 isFull;
  logic                 isEmpty;
  logic                 wtmHit;
  logic                 ingValid;
  logic [WORD_BITS-1:0] ingData;
  logic                 ingPop;
  logic                 takeSample;
  logic                 dropOldest;
  logic                 dropNew;
  logic                 ctrlWrite;
  logic                 cfgChange;
  logic                 dataRead;
  logic                 drainWord;
  logic                 statusRead;
  logic [7:0]           ctrlView;
  logic [7:0]           statusView;
  logic [WORD_BITS-1:0] headWord;

  ////////////////////////////////////////////////////////////////////////////
  // ingress buffer between the sensors and the sample store
  ssf_ingress_fifo #(
    .WIDTH (WORD_BITS),
    .DEPTH (INGRESS_DEPTH)
  ) u_ingress (
    .core_clk (core_clk),
    .resetn   (resetn),
    .inValid  (sampleIn.valid),
    .inData   (sampleIn.data),
    .inReady  (sampleReady),
    .outValid (ingValid),
    .outData  (ingData),
    .outReady (ingPop)
  );

  ////////////////////////////////////////////////////////////////////////////
  // capacity and occupancy
  assign capacity  = (PW+1)'(SSF_MIN_DEPTH) << depth_q;
  assign ptrMask   = PW'(capacity - (PW+1)'(1));
  assign isFull    = (count_q == capacity);
  assign isEmpty   = (count_q == '0);
  assign wordCount = 10'(count_q);
  assign wtmHit    = (threshold_q != 8'h00) && (wordCount >= {2'h0, threshold_q});

  // access decodes
  assign ctrlWrite  = regReq.wrEn && (regReq.addr == SSF_ADDR_CONTROL);
  assign cfgChange  = ctrlWrite &&
                      (regReq.wrData[3:0] != {depth_q, policy_q});
  assign dataRead   = regReq.rdEn && (regReq.addr == SSF_ADDR_DATA) && readPhase;
  assign drainWord  = dataRead && highByte_q && !isEmpty;
  assign statusRead = regReq.rdEn && (regReq.addr == SSF_ADDR_STATUS);

  // sample intake only in write phase; read phase stalls the ingress buffer
  always_comb begin
    takeSample = 1'b0;
    dropOldest = 1'b0;
    dropNew    = 1'b0;
    ingPop     = 1'b0;
    if (ingValid && !readPhase && !cfgChange) begin
      case (policy_q)
        SSF_POL_FILLONCE: begin
          ingPop     = 1'b1;
          takeSample = !isFull;
          dropNew    = isFull;
        end
        SSF_POL_STREAM: begin
          ingPop     = 1'b1;
          takeSample = 1'b1;
          dropOldest = isFull;
        end
        SSF_POL_BYPASS: begin
          ingPop = 1'b1;
        end
        default: begin
          ingPop = 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // threshold register
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      threshold_q <= SSF_THRESHOLD_RST;
    end else if (regReq.wrEn && (regReq.addr == SSF_ADDR_THRESHOLD)) begin
      threshold_q <= regReq.wrData;
    end
  end

  // control register: depth and policy; reserved bits are not stored
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      depth_q  <= SSF_DEPTH_RST;
      policy_q <= SSF_POL_BYPASS;
    end else if (ctrlWrite) begin
      depth_q  <= regReq.wrData[SSF_CTRL_DEPTH_LSB +: 2];
      policy_q <= ssf_policy_type'(regReq.wrData[SSF_CTRL_POLICY_LSB +: 2]);
    end
  end

  // read-phase bit: command sets it, host clears it, set wins
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      readPhase <= 1'b0;
    end else if (cmdEnterRead) begin
      readPhase <= 1'b1;
    end else if (ctrlWrite && !regReq.wrData[SSF_CTRL_READ_BIT]) begin
      readPhase <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sample store contents
  always_ff @(posedge core_clk) begin
    if (takeSample) begin
      store[wrPtr_q & ptrMask] <= ingData;
    end
  end

  // pointers and count; new geometry or policy empties the store
  always_ff @(posedge core_clk) begin
    if (!resetn || cfgChange) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (takeSample) begin
        wrPtr_q <= (wrPtr_q + PW'(1)) & ptrMask;
      end
      if (dropOldest || drainWord) begin
        rdPtr_q <= (rdPtr_q + PW'(1)) & ptrMask;
      end
      if (takeSample && !dropOldest) begin
        count_q <= count_q + (PW+1)'(1);
      end else if (drainWord) begin
        count_q <= count_q - (PW+1)'(1);
      end
    end
  end

  // overrun flag: set by lost data, cleared by a status read, set wins
  always_ff @(posedge core_clk) begin
    if (!resetn || cfgChange) begin
      overrun_q <= 1'b0;
    end else if (dropNew || dropOldest) begin
      overrun_q <= 1'b1;
    end else if (statusRead) begin
      overrun_q <= 1'b0;
    end
  end

  // byte lane of the data register: low byte first, word drains on high byte
  always_ff @(posedge core_clk) begin
    if (!resetn || !readPhase) begin
      highByte_q <= 1'b0;
    end else if (dataRead) begin
      highByte_q <= !highByte_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read views
  assign headWord = store[rdPtr_q];
  always_comb begin
    ctrlView                             = 8'h00;
    ctrlView[SSF_CTRL_READ_BIT]          = readPhase;
    ctrlView[SSF_CTRL_DEPTH_LSB +: 2]    = depth_q;
    ctrlView[SSF_CTRL_POLICY_LSB +: 2]   = policy_q;
    statusView                           = 8'h00;
    statusView[SSF_STAT_FULL_BIT]        = isFull;
    statusView[SSF_STAT_WTM_BIT]         = wtmHit;
    statusView[SSF_STAT_OVR_BIT]         = overrun_q;
    statusView[SSF_STAT_NEMPTY_BIT]      = !isEmpty;
    statusView[SSF_STAT_CNT_HI_LSB +: 2] = wordCount[9:8];
  end

  // registered read answer, one cycle after the request
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      regRdData  <= SSF_RDATA_RST;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regReq.rdEn;
      if (regReq.rdEn) begin
        case (regReq.addr)
          SSF_ADDR_THRESHOLD: regRdData <= threshold_q;
          SSF_ADDR_CONTROL:   regRdData <= ctrlView;
          SSF_ADDR_COUNT_LO:  regRdData <= wordCount[7:0];
          SSF_ADDR_STATUS:    regRdData <= statusView;
          SSF_ADDR_DATA: begin
            if (dataRead && !isEmpty) begin
              regRdData <= highByte_q ? headWord[15:8] : headWord[7:0];
            end else begin
              regRdData <= 8'h00;
            end
          end
          default:            regRdData <= 8'h00;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// File: design/ssf_pkg.sv
// Function
// - An eight-bit watermark threshold, zero after reset, sets the stored sample count that raises the watermark flag.
// - While the read-phase bit is 0 the buffer is in write phase and takes samples from the enabled sensors.
// - While the read-phase bit is 1 the buffered words are offered to the host through the data output register.
// - The read-phase bit, bit 7 of the control register, is set by the device itself on the matching host command.
// - Control bits 3:2, zero after reset, set the capacity: 16, 32, 64 or 128 samples.
// - Control bits 1:0, zero after reset, select bypass, fill-once or streaming, with code 3 reserved.
// - Control bits 6:4 are reserved, read as zero and do nothing.
// - The stored word count is reported as ten bits: eight low bits in one register, two high bits in status.
// - Status shows buffer full, watermark reached, overflow with data lost, and buffer not empty.
package ssf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [7:0] SSF_ADDR_THRESHOLD = 8'h13;
  localparam logic [7:0] SSF_ADDR_CONTROL   = 8'h14;
  localparam logic [7:0] SSF_ADDR_COUNT_LO  = 8'h15;
  localparam logic [7:0] SSF_ADDR_STATUS    = 8'h16;
  localparam logic [7:0] SSF_ADDR_DATA      = 8'h17;

  // control register fields
  localparam int SSF_CTRL_READ_BIT   = 7;
  localparam int SSF_CTRL_DEPTH_LSB  = 2;
  localparam int SSF_CTRL_POLICY_LSB = 0;

  // status register fields
  localparam int SSF_STAT_FULL_BIT    = 7;
  localparam int SSF_STAT_WTM_BIT     = 6;
  localparam int SSF_STAT_OVR_BIT     = 5;
  localparam int SSF_STAT_NEMPTY_BIT  = 4;
  localparam int SSF_STAT_CNT_HI_LSB  = 0;

  // reset values
  localparam logic [7:0] SSF_THRESHOLD_RST = 8'h00;
  localparam logic [1:0] SSF_DEPTH_RST     = 2'h0;
  localparam logic [7:0] SSF_RDATA_RST     = 8'h00;

  // sizes
  localparam int SSF_WORD_BITS    = 16;
  localparam int SSF_MIN_DEPTH    = 16;
  localparam int SSF_MAX_DEPTH    = 128;
  localparam int SSF_INGRESS_DEPTH = 16;

  ////////////////////////////////////////////////////////////////////////////
  // buffer policy codes
  typedef enum logic [1:0] {
    SSF_POL_BYPASS   = 2'h0,
    SSF_POL_FILLONCE = 2'h1,
    SSF_POL_STREAM   = 2'h2,
    SSF_POL_RESERVED = 2'h3
  } ssf_policy_type;

  // register access request from the host port
  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } ssf_reg_req_type;

  // one sensor sample word
  typedef struct packed {
    logic                     valid;
    logic [SSF_WORD_BITS-1:0] data;
  } ssf_sample_type;

endpackage

// File: design/ssf_ingress_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module ssf_ingress_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             resetn,
  // fill side
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output var  logic             inReady,
  // drain side
  output var  logic             outValid,
  output var  logic [WIDTH-1:0] outData,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             push;
  logic             pop;

  // handshakes
  assign push = inValid && inReady;
  assign pop  = outValid && outReady;
  assign outData = mem[rdPtr_q];

  // next occupancy
  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + (AW+1)'(1);
    end else if (pop && !push) begin
      cnt_d = cnt_q - (AW+1)'(1);
    end
  end

  // storage
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  // pointers, count and flags
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wrPtr_q  <= '0;
      rdPtr_q  <= '0;
      cnt_q    <= '0;
      inReady  <= 1'b0;
      outValid <= 1'b0;
    end else begin
      if (push) begin
        wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + AW'(1);
      end
      if (pop) begin
        rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + AW'(1);
      end
      cnt_q    <= cnt_d;
      inReady  <= (cnt_d != (AW+1)'(DEPTH));
      outValid <= (cnt_d != '0);
    end
  end
endmodule
`default_nettype wire

// File: sim/ssf_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ssf_checker
  import ssf_pkg::*;
#(
  parameter int WORD_BITS     = 16,
  parameter int INGRESS_DEPTH = 16
) (
  // clock and reset
  input wire logic                     core_clk,
  input wire logic                     resetn,
  // register side
  input wire ssf_pkg::ssf_reg_req_type regReq,
  input wire logic [7:0]               regRdData,
  input wire logic                     regRdValid,
  input wire logic                     cmdEnterRead,
  // sample side
  input wire ssf_pkg::ssf_sample_type  sampleIn,
  input wire logic                     sampleReady,
  input wire logic                     readPhase
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic ctlWr;
  logic clrWr;
  // host writes to the control register
  assign ctlWr = regReq.wrEn && regReq.addr == SSF_ADDR_CONTROL;
  assign clrWr = ctlWr && !regReq.wrData[SSF_CTRL_READ_BIT];

  ////////////////////////////////////////////////////////////////////////////
  chk_read_answer: assert property (regReq.rdEn |=> regRdValid)
    else $error("read answer missing");
  chk_answer_cause: assert property (regRdValid |-> $past(regReq.rdEn))
    else $error("read answer without read");
  chk_data_holds: assert property (!regReq.rdEn |=> $stable(regRdData))
    else $error("read data changed without read");
  chk_cmd_enter: assert property (cmdEnterRead |=> readPhase)
    else $error("command did not enter read phase");
  chk_phase_holds: assert property (readPhase && !clrWr |=> readPhase)
    else $error("read phase left without clear write");
  chk_clear_leaves: assert property (clrWr && !cmdEnterRead |=> !readPhase)
    else $error("clear write did not leave read phase");
  chk_no_host_set: assert property (!readPhase && !cmdEnterRead |=> !readPhase)
    else $error("read phase set without command");
  chk_ctrl_reserved: assert property (regReq.rdEn && regReq.addr == SSF_ADDR_CONTROL
    |=> regRdData[6:4] == 3'h0 && regRdData[SSF_CTRL_READ_BIT] == $past(readPhase))
    else $error("control readback wrong");
  chk_unmapped_zero: assert property (regReq.rdEn && (regReq.addr < SSF_ADDR_THRESHOLD || regReq.addr > SSF_ADDR_DATA)
    |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  // main scenarios
  cover property (cmdEnterRead);
  cover property (clrWr && readPhase);
  cover property (sampleIn.valid && !sampleReady);
endmodule
bind ssf_sample_fifo_control ssf_checker #(.WORD_BITS(WORD_BITS), .INGRESS_DEPTH(INGRESS_DEPTH)) i_ssf_checker (
  .core_clk(core_clk), .resetn(resetn), .regReq(regReq), .regRdData(regRdData), .regRdValid(regRdValid),
  .cmdEnterRead(cmdEnterRead), .sampleIn(sampleIn), .sampleReady(sampleReady), .readPhase(readPhase));
`default_nettype wire

// File: sim/ssf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ssf_host_model
  import ssf_pkg::*;
(
  // clock and answer
  input  wire logic                     core_clk,
  input  wire logic [7:0]               regRdData,
  input  wire logic                     regRdValid,
  // requests
  output var  ssf_pkg::ssf_reg_req_type regReq,
  output var  logic                     cmdEnterRead
);
  // idle at start
  initial begin
    regReq = '0;
    cmdEnterRead = 1'b0;
  end
  // one write, released lines flip so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge core_clk);
    regReq = '{1'b1, 1'b0, a, (a == SSF_ADDR_CONTROL) ? v & 8'h8F : v};
    @(negedge core_clk);
    regReq = '{1'b0, 1'b0, ~a, ~regReq.wrData};
  endtask
  // one read, answer taken one cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge core_clk);
    regReq = '{1'b0, 1'b1, a, ~regReq.wrData};
    @(negedge core_clk);
    v = (regRdValid === 1'b1) ? regRdData : 8'hxx;
    regReq = '{1'b0, 1'b0, ~a, regReq.wrData};
  endtask
  // predefined enter-read command
  task automatic cmd();
    @(negedge core_clk);
    cmdEnterRead = 1'b1;
    @(negedge core_clk);
    cmdEnterRead = 1'b0;
  endtask
endmodule
`default_nettype wire

// File: sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ssf_pkg::*;
  logic            core_clk;
  logic            resetn;
  ssf_reg_req_type regReq;
  logic [7:0]      regRdData;
  logic            regRdValid;
  logic            cmdEnterRead;
  ssf_sample_type  sampleIn;
  logic            sampleReady;
  logic            readPhase;
  int              n_mismatch;
  int              compares;
  int              k;

  ssf_sample_fifo_control i_ssf_sample_fifo_control (.core_clk(core_clk), .resetn(resetn), .regReq(regReq),
    .regRdData(regRdData), .regRdValid(regRdValid), .cmdEnterRead(cmdEnterRead), .sampleIn(sampleIn),
    .sampleReady(sampleReady), .readPhase(readPhase));
  ssf_host_model i_ssf_host_model (.core_clk(core_clk), .regRdData(regRdData), .regRdValid(regRdValid),
    .regReq(regReq), .cmdEnterRead(cmdEnterRead));

  // clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    i_ssf_host_model.rd(a, v);
    chk(v, exp);
  endtask
  // offer n samples, each held until taken
  task automatic push(input int n, input logic [15:0] base);
    int w;
    for (int i = 0; i < n; i++) begin
      @(negedge core_clk);
      sampleIn = '{1'b1, base + 16'(i)};
      w = 0;
      while (sampleReady !== 1'b1 && w < 100) begin
        @(negedge core_clk);
        w++;
      end
      @(posedge core_clk);
    end
    @(negedge core_clk);
    sampleIn.valid = 1'b0;
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog
  initial begin
    #100000;
    n_mismatch++;
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    sampleIn = '0;
    n_mismatch = 0;
    compares = 0;
    repeat (3) @(negedge core_clk);
    resetn = 1'b1;
    rdc(SSF_ADDR_THRESHOLD, 8'h00);
    rdc(SSF_ADDR_CONTROL, 8'h00);
    rdc(SSF_ADDR_STATUS, 8'h00);
    rdc(SSF_ADDR_COUNT_LO, 8'h00);
    $display("test reset done");
    i_ssf_host_model.wr(SSF_ADDR_THRESHOLD, 8'hA5);
    rdc(SSF_ADDR_THRESHOLD, 8'hA5);
    for (k = 0; k < 4; k++) begin
      i_ssf_host_model.wr(SSF_ADDR_CONTROL, 8'hF0 | 8'(k * 5));
      rdc(SSF_ADDR_CONTROL, 8'(k * 5));
    end
    $display("test registers done");
    i_ssf_host_model.wr(SSF_ADDR_THRESHOLD, 8'h04);
    i_ssf_host_model.wr(SSF_ADDR_CONTROL, 8'h01);
    push(20, 16'h1000);
    repeat (40) @(negedge core_clk);
    rdc(SSF_ADDR_COUNT_LO, 8'h10);
    rdc(SSF_ADDR_STATUS, 8'hF0);
    rdc(SSF_ADDR_STATUS, 8'hD0);
    $display("test fill-once done");
    i_ssf_host_model.cmd();
    chk({7'h0, readPhase}, 8'h01);
    rdc(SSF_ADDR_CONTROL, 8'h81);
    rdc(SSF_ADDR_DATA, 8'h00);
    rdc(SSF_ADDR_DATA, 8'h10);
    rdc(SSF_ADDR_COUNT_LO, 8'h0F);
    sampleIn = '{1'b1, 16'h3000};
    k = 0;
    repeat (30) begin
      if (sampleReady === 1'b1) k++;
      @(negedge core_clk);
    end
    sampleIn.valid = 1'b0;
    chk(8'(k), 8'(SSF_INGRESS_DEPTH));
    rdc(SSF_ADDR_COUNT_LO, 8'h0F);
    i_ssf_host_model.wr(SSF_ADDR_CONTROL, 8'h01);
    chk({7'h0, readPhase}, 8'h00);
    repeat (40) @(negedge core_clk);
    rdc(SSF_ADDR_COUNT_LO, 8'h10);
    $display("test read phase done");
    i_ssf_host_model.wr(SSF_ADDR_CONTROL, 8'h02);
    rdc(SSF_ADDR_COUNT_LO, 8'h00);
    push(20, 16'h2000);
    repeat (40) @(negedge core_clk);
    rdc(SSF_ADDR_STATUS, 8'hF0);
    i_ssf_host_model.cmd();
    rdc(SSF_ADDR_DATA, 8'h04);
    rdc(SSF_ADDR_DATA, 8'h20);
    i_ssf_host_model.wr(SSF_ADDR_CONTROL, 8'h02);
    $display("test stream done");
    i_ssf_host_model.wr(SSF_ADDR_CONTROL, 8'h00);
    push(4, 16'h4000);
    repeat (20) @(negedge core_clk);
    rdc(SSF_ADDR_COUNT_LO, 8'h00);
    i_ssf_host_model.wr(SSF_ADDR_COUNT_LO, 8'hFF);
    rdc(SSF_ADDR_COUNT_LO, 8'h00);
    rdc(8'h20, 8'h00);
    $display("test bypass done");
    report_and_stop();
  end
endmodule
`default_nettype wire
